// ===== rtl/fpc_feedback_pid_core.sv
`timescale 1ns/100ps
// Behaviour
// R1: no feedback: duty target is target minus 2048
// R2: no feedback: 2648 full forward, 2048 brakes
// R3: calculations run once every control period
// R4: analog 0 V to 0, 5 V to 4092
// R5: frequency mode counts feedback pulses per period
// R6: frequency raw is 2048 plus/minus count by direction
// R7: pulse count per period capped at 2047
// R8: minimum scales to 0, maximum to 4095
// R9: raw outside absolute limits flags disconnect
// R10: invert option reverses scaled feedback sense
// R11: analog raw is average of configured samples
// R12: flag when sampling overruns the control period
// R13: aux test drives pin low, expects 0 V
// R14: duty target is sum of three products
// R15: integral accumulates error; derivative is error difference
// R16: error is scaled feedback minus target
// R17: coefficients are numerator over power of two
// R18: integral denominator selectable 2^3 to 2^18
// R19: configurable control period sets calculation rate
// R20: reset clears integral, previous error; wide math
// R21: outputs registered once per period, held stable
module fpc_feedback_pid_core (
    input  wire logic                 clock_in,
    input  wire logic                 reset_in,
    input  wire logic [1:0]           feedback_mode_in,
    input  wire logic [11:0]          target_in,
    input  wire logic [15:0]          period_cycles_in,
    input  wire logic [2:0]           samples_log2_in,
    input  wire logic [11:0]          feedback_min_in,
    input  wire logic [11:0]          feedback_max_in,
    input  wire logic [11:0]          abs_min_in,
    input  wire logic [11:0]          abs_max_in,
    input  wire logic                 invert_feedback_in,
    input  wire logic                 aux_detect_in,
    input  wire logic [15:0]          prop_num_in,
    input  wire logic [3:0]           prop_shift_in,
    input  wire logic [15:0]          integ_num_in,
    input  wire logic [4:0]           integ_shift_in,
    input  wire logic [15:0]          deriv_num_in,
    input  wire logic [3:0]           deriv_shift_in,
    input  wire logic                 adc_done_in,
    input  wire logic [9:0]           adc_value_in,
    input  wire logic                 feedback_sense_pin_in,
    output logic                      adc_start_out,
    output logic                      aux_pin_out,
    output logic                      aux_pin_oe_out,
    output logic [11:0]               raw_feedback_out,
    output logic [11:0]               scaled_feedback_out,
    output logic signed [31:0]        duty_target_out,
    output logic                      disconnect_err_out,
    output logic                      period_exceeded_out,
    output logic                      update_strobe_out
);
    fpc_pkg::fpc_state_t                  state;
    logic [1:0]                           pin_sync;
    logic                                 pin_prev;
    logic [15:0]                          period_count;
    logic                                 period_tick;
    logic [10:0]                          pulse_count;
    logic [10:0]                          pulse_latched;
    logic [16:0]                          sample_sum;
    logic [7:0]                           sample_idx;
    logic [7:0]                           settle_count;
    logic                                 aux_fail;
    logic                                 limit_err;
    logic [23:0]                          div_quot;
    logic [11:0]                          div_rem;
    logic [11:0]                          div_den;
    logic [4:0]                           div_count;
    logic signed [31:0]                   integral;
    logic signed [12:0]                   prev_error;
    logic [16:0]                          sum_now;
    logic [12:0]                          rem_shift;
    logic [11:0]                          scaled_now;
    logic [11:0]                          raw_span;
    logic [4:0]                           ishift;
    logic signed [12:0]                   error_now;
    logic signed [13:0]                   deriv_now;
    logic signed [31:0]                   next_integral;
    logic signed [50:0]                   pid_sum;
    logic signed [31:0]                   next_duty;

    // two flops before anything looks at the pin
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            pin_sync <= 2'h0;
            pin_prev <= 1'b0;
        end
        else
        begin
            pin_sync <= {pin_sync[0], feedback_sense_pin_in};
            pin_prev <= pin_sync[1];
        end
    end

    // a period of zero cycles behaves as the longest period
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            period_count <= 16'h0;
            period_tick  <= 1'b0;
        end
        else if (period_count >= period_cycles_in - 16'h1) // R19
        begin
            period_count <= 16'h0;
            period_tick  <= 1'b1;
        end
        else
        begin
            period_count <= period_count + 16'h1;
            period_tick  <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            pulse_count   <= 11'h0;
            pulse_latched <= 11'h0;
        end
        else if (period_count >= period_cycles_in - 16'h1)
        begin
            pulse_latched <= pulse_count; // R5
            pulse_count   <= {10'h0, pin_sync[1] & ~pin_prev};
        end
        else if (pin_sync[1] && !pin_prev && pulse_count != fpc_pkg::PULSE_MAX) // R7
            pulse_count <= pulse_count + 11'h1;
    end

    // a tick that finds the sequencer busy is skipped and reported
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
            period_exceeded_out <= 1'b0;
        else if (period_tick)
            period_exceeded_out <= (state != fpc_pkg::ST_IDLE); // R12
    end

    always_comb
    begin
        sum_now    = sample_sum + {7'h0, adc_value_in};
        rem_shift  = {div_rem, div_quot[23]};
        raw_span   = feedback_max_in - feedback_min_in;
        scaled_now = (div_quot > {12'h0, fpc_pkg::RAW_FULL}) ? fpc_pkg::RAW_FULL
                                                              : div_quot[11:0];
        if (invert_feedback_in)
            scaled_now = fpc_pkg::RAW_FULL - scaled_now; // R10
        error_now     = $signed({1'b0, scaled_now}) - $signed({1'b0, target_in}); // R16
        deriv_now     = 14'(error_now) - 14'(prev_error); // R15
        next_integral = integral + 32'(error_now); // R15
        ishift        = integ_shift_in;
        if (ishift < fpc_pkg::ISHIFT_MIN)
            ishift = fpc_pkg::ISHIFT_MIN; // R18
        if (ishift > fpc_pkg::ISHIFT_MAX)
            ishift = fpc_pkg::ISHIFT_MAX; // R18
        // R17: each product is shifted down by its power-of-two denominator
        pid_sum = (51'($signed({1'b0, prop_num_in}) * error_now) >>> prop_shift_in)
                + (51'($signed({1'b0, integ_num_in}) * next_integral) >>> ishift)
                + (51'($signed({1'b0, deriv_num_in}) * deriv_now) >>> deriv_shift_in); // R14
        // saturate rather than wrap when the sum leaves the output range
        if (pid_sum[50] && !(&pid_sum[50:31]))
            next_duty = {1'b1, 31'h0};
        else if (!pid_sum[50] && (|pid_sum[50:31]))
            next_duty = {1'b0, {31{1'b1}}};
        else
            next_duty = pid_sum[31:0];
        if (feedback_mode_in == fpc_pkg::MODE_NONE)
            next_duty = 32'($signed({1'b0, target_in}) - $signed({1'b0, fpc_pkg::RAW_MID})); // R1 R2
    end

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state               <= fpc_pkg::ST_IDLE;
            adc_start_out       <= 1'b0;
            aux_pin_out         <= 1'b0;
            aux_pin_oe_out      <= 1'b0;
            raw_feedback_out    <= 12'h0;
            scaled_feedback_out <= 12'h0;
            duty_target_out     <= 32'sh0;
            disconnect_err_out  <= 1'b0;
            update_strobe_out   <= 1'b0;
            sample_sum          <= 17'h0;
            sample_idx          <= 8'h0;
            settle_count        <= 8'h0;
            aux_fail            <= 1'b0;
            limit_err           <= 1'b0;
            div_quot            <= 24'h0;
            div_rem             <= 12'h0;
            div_den             <= 12'h0;
            div_count           <= 5'h0;
            integral            <= 32'sh0; // R20
            prev_error          <= 13'sh0; // R20
        end
        else
        begin
            update_strobe_out <= 1'b0;
            adc_start_out     <= 1'b0;
            aux_pin_oe_out    <= 1'b1;
            case (state)
                fpc_pkg::ST_IDLE:
                begin
                    aux_pin_out <= 1'b1;
                    if (period_tick) // R3
                    begin
                        aux_fail <= 1'b0;
                        if (feedback_mode_in == fpc_pkg::MODE_ANALOG)
                        begin
                            sample_sum    <= 17'h0;
                            sample_idx    <= 8'h0;
                            adc_start_out <= 1'b1;
                            state         <= fpc_pkg::ST_SAMPLE;
                        end
                        else if (feedback_mode_in == fpc_pkg::MODE_FREQ)
                        begin
                            if (target_in > fpc_pkg::RAW_MID)
                                raw_feedback_out <= fpc_pkg::RAW_MID + {1'b0, pulse_latched}; // R6
                            else
                                raw_feedback_out <= fpc_pkg::RAW_MID - {1'b0, pulse_latched}; // R6
                            state <= fpc_pkg::ST_CHECK;
                        end
                        else
                            state <= fpc_pkg::ST_PID; // R3
                    end
                end
                fpc_pkg::ST_SAMPLE:
                    if (adc_done_in)
                    begin
                        sample_sum <= sum_now;
                        if (sample_idx == 8'((9'h1 << samples_log2_in) - 9'h1))
                        begin
                            // R4 R11: average in converter counts, then four per count
                            raw_feedback_out <= {10'(sum_now >> samples_log2_in), fpc_pkg::ADC_PAD};
                            settle_count     <= 8'h0;
                            aux_pin_out      <= !aux_detect_in; // R13
                            state <= aux_detect_in ? fpc_pkg::ST_AUX_SETTLE : fpc_pkg::ST_CHECK;
                        end
                        else
                        begin
                            sample_idx    <= sample_idx + 8'h1;
                            adc_start_out <= 1'b1;
                        end
                    end
                fpc_pkg::ST_AUX_SETTLE:
                begin
                    settle_count <= settle_count + 8'h1;
                    if (settle_count >= fpc_pkg::AUX_SETTLE_CNT - 8'h1)
                    begin
                        adc_start_out <= 1'b1;
                        state         <= fpc_pkg::ST_AUX_SAMPLE;
                    end
                end
                fpc_pkg::ST_AUX_SAMPLE:
                    if (adc_done_in)
                    begin
                        aux_fail    <= {adc_value_in, fpc_pkg::ADC_PAD} > fpc_pkg::AUX_ZERO_MAX; // R13
                        aux_pin_out <= 1'b1;
                        state       <= fpc_pkg::ST_CHECK;
                    end
                fpc_pkg::ST_CHECK:
                begin
                    limit_err <= raw_feedback_out < abs_min_in
                              || raw_feedback_out > abs_max_in; // R9
                    div_den   <= raw_span;
                    div_rem   <= 12'h0;
                    div_count <= fpc_pkg::DIV_STEPS;
                    // clamp to the calibrated span, then times 4095
                    if (raw_feedback_out <= feedback_min_in)
                        div_quot <= 24'h0;
                    else if (raw_feedback_out >= feedback_max_in)
                        div_quot <= 24'(raw_span * fpc_pkg::RAW_FULL); // R8
                    else
                        div_quot <= 24'((raw_feedback_out - feedback_min_in) * fpc_pkg::RAW_FULL);
                    state <= fpc_pkg::ST_SCALE;
                end
                fpc_pkg::ST_SCALE:
                begin
                    // restoring divide, one quotient bit a cycle to keep it small
                    if (rem_shift >= {1'b0, div_den})
                    begin
                        div_rem  <= 12'(rem_shift - {1'b0, div_den});
                        div_quot <= {div_quot[22:0], 1'b1};
                    end
                    else
                    begin
                        div_rem  <= rem_shift[11:0];
                        div_quot <= {div_quot[22:0], 1'b0};
                    end
                    div_count <= div_count - 5'h1;
                    if (div_count == 5'h1)
                        state <= fpc_pkg::ST_PID;
                end
                fpc_pkg::ST_PID:
                begin
                    update_strobe_out <= 1'b1; // R21
                    duty_target_out   <= next_duty; // R14 R1
                    if (feedback_mode_in == fpc_pkg::MODE_NONE)
                        disconnect_err_out <= 1'b0;
                    else
                    begin
                        scaled_feedback_out <= scaled_now; // R21
                        disconnect_err_out  <= limit_err | aux_fail; // R9 R13
                        integral            <= next_integral; // R15
                        prev_error          <= error_now; // R15
                    end
                    state <= fpc_pkg::ST_IDLE;
                end
                default:
                    state <= fpc_pkg::ST_IDLE;
            endcase
        end
    end

    logic [1:0] strobes_in_period;
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
            strobes_in_period <= 2'h0;
        else if (period_tick)
            strobes_in_period <= 2'h0;
        else if (update_strobe_out && strobes_in_period != 2'h3)
            strobes_in_period <= strobes_in_period + 2'h1;
    end

    sequence s_pid_done;
        ##[1:40] update_strobe_out;
    endsequence
    sequence s_tick_idle;
        period_tick && state == fpc_pkg::ST_IDLE;
    endsequence

    none_bypass_a: assert property (@(posedge clock_in) disable iff (reset_in) // R1
        update_strobe_out && $past(feedback_mode_in) == fpc_pkg::MODE_NONE
        |-> duty_target_out == 32'($signed({1'b0, $past(target_in)}) - 13'sh800))
        else $error("no-feedback duty target wrong");
    full_fwd_a: assert property (@(posedge clock_in) disable iff (reset_in) // R2
        update_strobe_out && $past(feedback_mode_in) == fpc_pkg::MODE_NONE
        && $past(target_in) == 12'ha58 |-> duty_target_out == 32'sh258)
        else $error("target 2648 not full forward");
    once_per_a: assert property (@(posedge clock_in) disable iff (reset_in) // R3
        strobes_in_period <= 2'h1)
        else $error("more than one calculation in a period");
    tick_start_a: assert property (@(posedge clock_in) disable iff (reset_in) // R3
        s_tick_idle |=> state != fpc_pkg::ST_IDLE)
        else $error("period tick did not start a calculation");
    analog_raw_a: assert property (@(posedge clock_in) disable iff (reset_in) // R4
        update_strobe_out && $past(feedback_mode_in) == fpc_pkg::MODE_ANALOG
        |-> raw_feedback_out[1:0] == 2'h0)
        else $error("analog raw not a multiple of four");
    pulse_cap_a: assert property (@(posedge clock_in) disable iff (reset_in) // R7
        pulse_count <= fpc_pkg::PULSE_MAX)
        else $error("pulse count above cap");
    freq_raw_a: assert property (@(posedge clock_in) disable iff (reset_in) // R6
        s_tick_idle and feedback_mode_in == fpc_pkg::MODE_FREQ |=>
        raw_feedback_out == (($past(target_in) > 12'h800)
            ? 12'h800 + {1'b0, $past(pulse_latched)} : 12'h800 - {1'b0, $past(pulse_latched)}))
        else $error("frequency raw feedback wrong");
    scale_min_a: assert property (@(posedge clock_in) disable iff (reset_in) // R8
        state == fpc_pkg::ST_CHECK && raw_feedback_out <= feedback_min_in
        && !invert_feedback_in && $stable(invert_feedback_in)
        |-> s_pid_done ##0 (scaled_feedback_out == 12'h0 || $changed(invert_feedback_in)))
        else $error("minimum did not scale to zero");
    limit_err_a: assert property (@(posedge clock_in) disable iff (reset_in) // R9
        state == fpc_pkg::ST_CHECK && raw_feedback_out > abs_max_in
        |-> s_pid_done ##0 disconnect_err_out)
        else $error("out of range raw not flagged");
    aux_low_a: assert property (@(posedge clock_in) disable iff (reset_in) // R13
        state == fpc_pkg::ST_AUX_SAMPLE |-> !aux_pin_out && aux_pin_oe_out)
        else $error("aux pin not driven low during test");
    overrun_a: assert property (@(posedge clock_in) disable iff (reset_in) // R12
        period_tick && state != fpc_pkg::ST_IDLE |=> period_exceeded_out)
        else $error("overrun not reported");
    integ_acc_a: assert property (@(posedge clock_in) disable iff (reset_in) // R15
        update_strobe_out && $past(feedback_mode_in) != fpc_pkg::MODE_NONE
        |-> integral == $past(integral) + 32'($past(error_now)) && prev_error == $past(error_now))
        else $error("integral or previous error not updated");
    ishift_a: assert property (@(posedge clock_in) disable iff (reset_in) // R18
        ishift >= 5'h03 && ishift <= 5'h12)
        else $error("integral denominator out of range");
endmodule // fpc_feedback_pid_core

// ===== rtl/fpc_pkg.sv
package fpc_pkg;
    localparam int          RAW_W       = 12;
    localparam int          ADC_W       = 10;
    localparam int          NUM_W       = 16;
    localparam int          ERR_W       = 13;
    localparam int          INT_W       = 32;
    localparam int          DUTY_W      = 32;
    localparam int          SUM_W       = 51;
    localparam int          PER_W       = 16;
    localparam int          DIV_W       = 24;
    localparam int          CLOCK_MHZ   = 20;
    localparam logic [11:0] RAW_MID     = 12'h800;
    localparam logic [11:0] RAW_FULL    = 12'hfff;
    localparam logic [10:0] PULSE_MAX   = 11'h7ff;
    localparam logic [1:0]  ADC_PAD     = 2'h0;
    localparam logic [4:0]  DIV_STEPS   = 5'h18;
    localparam logic [4:0]  ISHIFT_MIN  = 5'h03;
    localparam logic [4:0]  ISHIFT_MAX  = 5'h12;
    localparam logic [11:0] AUX_ZERO_MAX = 12'h010;
    localparam logic [1:0]  MODE_NONE   = 2'h0;
    localparam logic [1:0]  MODE_ANALOG = 2'h1;
    localparam logic [1:0]  MODE_FREQ   = 2'h2;
    // pot settle time after the aux pin changes level
    localparam int          AUX_SETTLE_NS  = 10000;
    localparam int          AUX_SETTLE_CYC = (AUX_SETTLE_NS * CLOCK_MHZ + 999) / 1000;
    localparam logic [7:0]  AUX_SETTLE_CNT = 8'(AUX_SETTLE_CYC);

    typedef enum logic [6:0] {
        ST_IDLE       = 7'h01,
        ST_SAMPLE     = 7'h02,
        ST_AUX_SETTLE = 7'h04,
        ST_AUX_SAMPLE = 7'h08,
        ST_CHECK      = 7'h10,
        ST_SCALE      = 7'h20,
        ST_PID        = 7'h40
    } fpc_state_t;
endpackage

// ===== verif/fpc_sensor_model.sv
`timescale 1ns/100ps
// pot on aux pin plus converter, and a tachometer pulse source
module fpc_sensor_model (
    input  wire logic       clock_in,
    input  wire logic       adc_start_in,
    input  wire logic       aux_low_in,
    input  wire logic       wired_in,
    input  wire logic [9:0] level_in,
    input  wire logic [7:0] delay_in,
    input  wire logic [7:0] pulse_gap_in,
    output logic            adc_done_out = 1'b0,
    output logic [9:0]      adc_value_out = 10'h000,
    output logic            pulse_out = 1'b0
);
    logic       busy = 1'b0;
    logic [7:0] wait_cnt = 8'h00;
    logic [7:0] gap_cnt = 8'h00;
    logic [9:0] held = 10'h000;
    always_ff @(posedge clock_in)
    begin
        adc_done_out <= 1'b0;
        // no stale result between conversions
        adc_value_out <= ~adc_value_out;
        if (adc_start_in)
        begin
            busy <= 1'b1;
            wait_cnt <= delay_in;
            // a wired pot reads 0 v with its top end pulled low
            held <= (aux_low_in && wired_in) ? 10'h000 : level_in;
        end
        else if (busy && wait_cnt == 8'h00)
        begin
            busy <= 1'b0;
            adc_done_out <= 1'b1;
            adc_value_out <= held;
        end
        else if (busy)
            wait_cnt <= wait_cnt - 8'h01;
    end
    always_ff @(posedge clock_in)
    begin
        gap_cnt <= (gap_cnt == 8'h00) ? pulse_gap_in - 8'h01 : gap_cnt - 8'h01;
        pulse_out <= (pulse_gap_in != 8'h00) && (gap_cnt == 8'h00);
    end
endmodule // fpc_sensor_model

// ===== verif/fpc_feedback_pid_core_bench.sv
`timescale 1ns/100ps
module fpc_feedback_pid_core_bench;
    logic        clock_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [1:0]  mode = 2'h0;
    logic [15:0] period = 16'h0064;
    logic [11:0] target = 12'h800, fmin = 12'h000, fmax = 12'hfff, amin = 12'h000, amax = 12'hfff;
    logic [15:0] kp = 16'h0001, ki = 16'h0000, kd = 16'h0000;
    logic [2:0]  nsamp = 3'h2;
    logic [9:0]  level = 10'h100;
    logic [7:0]  delay = 8'h03, gap = 8'h00;
    logic        inv = 1'b0, aux_en = 1'b0, wired = 1'b1;
    logic        done, start, aux, aux_oe, pin, dis, over, strobe_seen;
    logic [9:0]  value;
    logic [11:0] raw, scaled, sx;
    logic signed [31:0] duty, d0;
    int          mismatches = 0, check_count = 0, cycles = 0, g;
    logic [31:0] seed = 32'hb2e2;
    fpc_feedback_pid_core fpc_feedback_pid_core_i (.clock_in(clock_in), .reset_in(reset_in),
        .feedback_mode_in(mode), .target_in(target), .period_cycles_in(period),
        .samples_log2_in(nsamp), .feedback_min_in(fmin), .feedback_max_in(fmax),
        .abs_min_in(amin), .abs_max_in(amax), .invert_feedback_in(inv), .aux_detect_in(aux_en),
        .prop_num_in(kp), .prop_shift_in(4'h0), .integ_num_in(ki), .integ_shift_in(5'h00),
        .deriv_num_in(kd), .deriv_shift_in(4'h1), .adc_done_in(done), .adc_value_in(value),
        .feedback_sense_pin_in(pin), .adc_start_out(start), .aux_pin_out(aux),
        .aux_pin_oe_out(aux_oe), .raw_feedback_out(raw), .scaled_feedback_out(scaled),
        .duty_target_out(duty), .disconnect_err_out(dis), .period_exceeded_out(over),
        .update_strobe_out(strobe_seen));
    fpc_sensor_model fpc_sensor_model_i (.clock_in(clock_in), .adc_start_in(start),
        .aux_low_in(aux_oe & ~aux), .wired_in(wired), .level_in(level), .delay_in(delay),
        .pulse_gap_in(gap), .adc_done_out(done), .adc_value_out(value), .pulse_out(pin));
    initial
    begin
        forever #25 clock_in = ~clock_in;
    end
    always @(posedge clock_in)
    begin
        cycles++;
        // longest path is two 8192-cycle frequency periods; leave wide margin
        if (cycles == 80000)
        begin
            mismatches++;
            conclude();
        end
    end
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
        end
    endtask
    task automatic run(input int n);
        repeat (n)
        begin
            g = 1;
            @(posedge clock_in);
            #5;
            while (strobe_seen !== 1'b1)
            begin
                @(posedge clock_in);
                #5;
                g++;
            end
        end
    endtask
    function automatic logic [11:0] scale(input logic [11:0] r, lo, hi, input logic iv);
        logic [11:0] x;
        x = (r <= lo) ? 12'h000 : (r >= hi) ? 12'hfff : 12'(((r - lo) * 4095) / (hi - lo));
        return iv ? 12'hfff - x : x;
    endfunction
    task automatic freq(input logic [15:0] p, input logic [7:0] gp, input logic [11:0] t,
                        input logic [11:0] exp_raw);
        period = p;
        gap = gp;
        target = t;
        run(2);
        check("freq raw", {20'h0, exp_raw}, {20'h0, raw});
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clock_in);
        #5 reset_in = 1'b0;
        check("aux oe in reset", 32'h0, {31'h0, aux_oe});
        for (int i = 0; i < 4; i++)
        begin
            target = (i == 0) ? 12'ha58 : (i == 1) ? 12'h800 : 12'($random(seed));
            run(2);
            check("none duty", {20'h0, target} - 32'h800, duty);
            check("strobe gap", 32'd100, g);
            check("none disconnect", 32'h0, {31'h0, dis});
        end
        $display("test none done");
        mode = 2'h1;
        period = 16'h03e8;
        for (int i = 0; i < 6; i++)
        begin
            level = 10'($random(seed)) | 10'h011;
            fmin = 12'($random(seed)) & 12'h7ff;
            fmax = fmin + (12'($random(seed)) & 12'h7ff);
            inv = i[0];
            nsamp = 3'(i);
            aux_en = (i >= 4);
            wired = (i != 5);
            amin = (i == 2) ? {level, 2'h0} + 12'h001 : 12'h000;
            amax = (i == 3) ? {level, 2'h0} - 12'h001 : 12'hfff;
            run(2);
            sx = scale({level, 2'h0}, fmin, fmax, inv);
            check("analog raw", {20'h0, level, 2'h0}, {20'h0, raw});
            check("scaled", {20'h0, sx}, {20'h0, scaled});
            check("duty", {20'h0, sx} - {20'h0, target}, duty);
            check("disconnect", (i == 2 || i == 3 || i == 5), {31'h0, dis});
        end
        $display("test analog done");
        aux_en = 1'b0;
        kp = 16'h0000;
        ki = 16'h0008;
        run(2);
        d0 = duty;
        run(1);
        check("integral step", {20'h0, sx} - {20'h0, target}, duty - d0);
        // kd 2 over 2^1: a target step of +5 gives a derivative term of -5
        ki = 16'h0000;
        kd = 16'h0002;
        target = 12'h400;
        run(1);
        target = 12'h405;
        run(1);
        check("derivative", 32'hffff_fffb, duty);
        $display("test integral done");
        period = 16'h0032;
        delay = 8'h64;
        repeat (300) @(posedge clock_in);
        check("overrun", 32'h1, {31'h0, over});
        mode = 2'h0;
        period = 16'h0064;
        run(2);
        check("overrun cleared", 32'h0, {31'h0, over});
        $display("test overrun done");
        mode = 2'h2;
        fmin = 12'h000;
        fmax = 12'hfff;
        freq(16'h0190, 8'h0a, 12'hbb8, 12'h828);
        freq(16'h0190, 8'h0a, 12'h3e8, 12'h7d8);
        freq(16'h0190, 8'h0a, 12'h800, 12'h7d8);
        freq(16'h2000, 8'h02, 12'hfa0, 12'hfff);
        $display("test frequency done");
        conclude();
    end
endmodule // fpc_feedback_pid_core_bench
